// ===== logic/sep_pkg.sv
// shared constants for the eeprom command and protection decoder
package sep_pkg;
  localparam logic [3:0] SEP_TYPE_ARRAY   = 4'ha;
  localparam logic [3:0] SEP_TYPE_PROTECT = 4'h6;
  localparam logic [3:0] SEP_TYPE_THERMAL = 4'h3;
  localparam logic [2:0] SEP_CMD_BLK0     = 3'h1;
  localparam logic [2:0] SEP_CMD_BLK1     = 3'h4;
  localparam logic [2:0] SEP_CMD_BLK2     = 3'h5;
  localparam logic [2:0] SEP_CMD_BLK3     = 3'h0;
  localparam logic [2:0] SEP_CMD_CLEAR    = 3'h3;
  localparam logic [2:0] SEP_CMD_PAGE0    = 3'h6;
  localparam logic [2:0] SEP_CMD_PAGE1    = 3'h7;
  localparam int         SEP_MEM_DEPTH    = 512;
  localparam int         SEP_PAGE_BYTES   = 16;
  localparam logic [7:0] SEP_ERASED       = 8'hff;
  localparam logic [3:0] SEP_BIT_LAST     = 4'h7;
  localparam logic [3:0] SEP_PAGE_LAST    = 4'hf;
  localparam logic [3:0] SEP_PROT_NONE    = 4'h0;
  // program cycle time in microseconds
  localparam int         SEP_TW_US        = 5;
  localparam int         SEP_CLK_MHZ      = 125;
  localparam int         SEP_TW_CYC       = SEP_TW_US * SEP_CLK_MHZ;
  typedef enum logic [2:0] {
    SEP_IDLE = 3'b000,
    SEP_SEL  = 3'b001,
    SEP_ADDR = 3'b010,
    SEP_DATA = 3'b011,
    SEP_ACK  = 3'b100,
    SEP_SKIP = 3'b101
  } sep_state_t;
endpackage

// ===== logic/sep_eeprom_cmd.sv
// i2c target: select decode, block protection, page select and byte/page write
`timescale 1ns/100ps
// How it works
// - upper nibble of select byte picks array, protection/page or thermal section.
// - array and thermal selects need select field equal to strap-formed address.
// - protection and page commands ignore the logical bus address entirely.
// - select byte arrives msb first; bit zero is direction, one means read.
// - matching select is acknowledged in ninth bit; mismatch releases bus.
// - set or clear protection only while the high_voltage_level input is high.
// - bits three to one choose block, clear or page command; bit zero set makes it a query.
// - four blocks of 128 bytes, two per page.
// - protection bits are held in storage kept across power cycles.
// - set protects one named block; clear unprotects all four.
// - protection query acks when block is free, nacks when protected.
// - page select chooses lower or upper 256 bytes for later accesses.
// - page select returns to zero after every reset.
// - page query acks on page zero and nacks on page one.
// - don't-care bytes after protection or page commands get ack only while high_voltage_level is high.
// - write: ack select, ack address byte, then take data bytes.
// - programming starts only on stop in the tenth slot right after ack.
// - during programming the memory side ignores the bus; thermal still answers.
// - address counter steps after each written byte, not for protected blocks.
// - data byte to protected block is nacked and memory stays unchanged.
// - up to sixteen bytes latched per page write, one program cycle.
// - array reads as all ones before any programming.
module sep_eeprom_cmd
  import sep_pkg::*;
#(
  parameter int TW_CYCLES = SEP_TW_CYC
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // two-wire bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address straps and high voltage level
  input  wire logic       address_strap_zero,
  input  wire logic       address_strap_one,
  input  wire logic       address_strap_two,
  input  wire logic       high_voltage_level,
  // status
  output logic            program_busy,
  output logic            array_page,
  output logic [3:0]      block_protected,
  output logic            thermal_select,
  output logic [7:0]      thermal_byte,
  output logic            thermal_byte_valid
);
  import sep_pkg::*;

  // three-stage pin sync; stage one only feeds stage two
  logic [2:0] scl_s_q, sda_s_q;
  logic       scl_f_q, sda_f_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], scl_in};
      sda_s_q <= {sda_s_q[1:0], sda_in};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
    end
  end
  logic scl_p_q, sda_p_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end
  wire scl_rise = scl_f_q & ~scl_p_q;
  wire scl_fall = ~scl_f_q & scl_p_q;
  wire start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  wire stop_ev  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // block number from page bit and address bit 7
  function automatic logic [1:0] blk_of(input logic pg, input logic [7:0] a);
    blk_of = {pg, a[7]};
  endfunction
  // block named by a protection command code; valid flag in msb
  function automatic logic [2:0] cmd_blk(input logic [2:0] c);
    case (c)
      SEP_CMD_BLK0: cmd_blk = 3'h4;
      SEP_CMD_BLK1: cmd_blk = 3'h5;
      SEP_CMD_BLK2: cmd_blk = 3'h6;
      SEP_CMD_BLK3: cmd_blk = 3'h7;
      default:      cmd_blk = 3'h0;
    endcase
  endfunction

  wire [2:0] lba = {address_strap_two, address_strap_one, address_strap_zero};

  sep_state_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic       ack_q;       // drive ack in coming ninth bit
  logic       rd_q;
  logic [3:0] kind_q;      // type of current select
  logic [2:0] cmd_q;
  logic       from_data_q; // ack slot follows a data byte
  logic       wr_arm_q;    // program on stop
  logic       in_data_q;
  logic [7:0] addr_q;
  logic [7:0] buf_q [SEP_PAGE_BYTES];
  logic [7:0] bufa_q [SEP_PAGE_BYTES];
  logic [4:0] nbuf_q;
  logic [1:0] pend_q;      // 1 set, 2 clear, 3 data program
  logic [2:0] pblk_q;
  logic [$clog2(TW_CYCLES+1)-1:0] tw_q;
  logic       page_q;
  // nonvolatile models: no reset touches them, only their delivered state
  logic [3:0] prot_q = SEP_PROT_NONE;
  logic [7:0] mem_q [SEP_MEM_DEPTH] = '{default: SEP_ERASED};

  wire drop_sel = program_busy & (sh_q[7:4] != SEP_TYPE_THERMAL);
  // block named by the command in the shifter; valid flag in msb
  wire [2:0] sel_blk = cmd_blk(sh_q[3:1]);

  // byte engine: bits in on scl rise, ack on ninth bit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= SEP_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
      kind_q <= 4'h0;
      cmd_q <= 3'h0;
      from_data_q <= 1'b0;
      in_data_q <= 1'b0;
      thermal_byte_valid <= 1'b0;
      thermal_byte <= 8'h00;
    end else begin
      thermal_byte_valid <= 1'b0;
      if (start_ev) begin
        st_q <= SEP_SEL;
        bit_q <= 4'h0;
        in_data_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= SEP_IDLE;
      end else if (scl_rise && st_q inside {SEP_SEL, SEP_ADDR, SEP_DATA, SEP_SKIP}) begin
        sh_q <= {sh_q[6:0], sda_f_q};
        bit_q <= bit_q + 4'h1;
      end else if (scl_fall && bit_q == 4'h8) begin
        bit_q <= 4'h0;
        st_q <= SEP_ACK;
        ack_q <= 1'b0;
        from_data_q <= (st_q == SEP_DATA); // only data bytes reach the page buffer
        case (st_q)
          SEP_SEL: begin
            kind_q <= sh_q[7:4];
            cmd_q <= sh_q[3:1];
            rd_q <= sh_q[0];
            if (sh_q[7:4] == SEP_TYPE_ARRAY && sh_q[3:1] == lba && !drop_sel)
              ack_q <= 1'b1;
            else if (sh_q[7:4] == SEP_TYPE_THERMAL && sh_q[3:1] == lba)
              ack_q <= 1'b1;
            else if (sh_q[7:4] == SEP_TYPE_PROTECT && !drop_sel) begin
              if (sh_q[0])
                ack_q <= (sh_q[3:1] == SEP_CMD_PAGE0) ? ~page_q
                       : sel_blk[2] & ~prot_q[sel_blk[1:0]];
              else if (sh_q[3:1] == SEP_CMD_PAGE0 || sh_q[3:1] == SEP_CMD_PAGE1)
                ack_q <= 1'b1;
              else if (sel_blk[2] || sh_q[3:1] == SEP_CMD_CLEAR)
                ack_q <= high_voltage_level &
                         ~(sel_blk[2] & prot_q[sel_blk[1:0]]);
            end
          end
          SEP_ADDR: begin
            ack_q <= (kind_q == SEP_TYPE_ARRAY) || (kind_q == SEP_TYPE_THERMAL)
                   || high_voltage_level;
            in_data_q <= 1'b1;
          end
          SEP_DATA: begin
            if (kind_q == SEP_TYPE_ARRAY)
              ack_q <= ~prot_q[blk_of(page_q, addr_q)];
            else if (kind_q == SEP_TYPE_THERMAL) begin
              ack_q <= 1'b1;
              thermal_byte <= sh_q;
              thermal_byte_valid <= 1'b1;
            end else
              ack_q <= high_voltage_level;
          end
          default: ack_q <= 1'b0;
        endcase
      end else if (scl_fall && st_q == SEP_ACK) begin
        if (!ack_q || rd_q) st_q <= SEP_IDLE; // release; reads are out of scope
        else st_q <= in_data_q ? SEP_DATA : SEP_ADDR;
        ack_q <= 1'b0;
      end
    end
  end

  // open-drain ack; only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (reset) sda_oe <= 1'b0;
    else if (scl_fall) sda_oe <= (st_q != SEP_ACK) && (bit_q == 4'h8) ? 1'b0 : sda_oe;
    else if (st_q == SEP_ACK) sda_oe <= ack_q;
    else sda_oe <= 1'b0;
  end
  assign sda_out = 1'b0;

  // address counter and page buffer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      addr_q <= 8'h00;
      nbuf_q <= 5'h00;
      wr_arm_q <= 1'b0;
    end else if (start_ev) begin
      // a start while programming must not lose the latched page
      if (!program_busy) nbuf_q <= 5'h00;
      wr_arm_q <= 1'b0;
    end else if (scl_fall && st_q == SEP_ACK && ack_q) begin
      if (kind_q == SEP_TYPE_ARRAY && from_data_q && !rd_q) begin
        if (nbuf_q < 5'(SEP_PAGE_BYTES)) begin
          buf_q[nbuf_q[3:0]] <= sh_q;
          bufa_q[nbuf_q[3:0]] <= addr_q;
          nbuf_q <= nbuf_q + 5'h1;
        end
        addr_q <= {addr_q[7:4], addr_q[3:0] + 4'h1};
      end
      wr_arm_q <= 1'b1;
    end else if (scl_fall) begin
      // a stop comes while scl is high, so any later fall means a bit slot
      wr_arm_q <= 1'b0;
    end
    if (!reset && st_q == SEP_ADDR && scl_fall && bit_q == 4'h8 && kind_q == SEP_TYPE_ARRAY)
      addr_q <= sh_q;
  end

  // program cycle: protection bits and array writes; page select applies at once on the stop
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page_q <= 1'b0;
      pend_q <= 2'h0;
      tw_q <= '0;
      pblk_q <= 3'h0;
    end else begin
      if (tw_q != '0) tw_q <= tw_q - 1'b1;
      // queries and thermal writes never start a program cycle
      if (stop_ev && wr_arm_q && !rd_q && tw_q == '0
          && kind_q inside {SEP_TYPE_PROTECT, SEP_TYPE_ARRAY}) begin
        if (kind_q == SEP_TYPE_PROTECT && cmd_q == SEP_CMD_PAGE0) page_q <= 1'b0;
        else if (kind_q == SEP_TYPE_PROTECT && cmd_q == SEP_CMD_PAGE1) page_q <= 1'b1;
        else begin
          tw_q <= TW_CYCLES[$bits(tw_q)-1:0];
          if (kind_q == SEP_TYPE_PROTECT && cmd_q == SEP_CMD_CLEAR) pend_q <= 2'h2;
          else if (kind_q == SEP_TYPE_PROTECT) begin
            pend_q <= 2'h1;
            pblk_q <= cmd_blk(cmd_q);
          end else if (kind_q == SEP_TYPE_ARRAY) pend_q <= 2'h3;
        end
      end
      if (tw_q == 1) begin
        case (pend_q)
          2'h1: prot_q[pblk_q[1:0]] <= 1'b1;
          2'h2: prot_q <= SEP_PROT_NONE;
          2'h3: for (int i = 0; i < SEP_PAGE_BYTES; i++)
            if (5'(i) < nbuf_q) mem_q[{page_q, bufa_q[i]}] <= buf_q[i];
          default: ;
        endcase
        pend_q <= 2'h0;
      end
    end
  end

  assign program_busy    = (tw_q != '0);
  assign array_page      = page_q;
  assign block_protected = prot_q;
  assign thermal_select  = (kind_q == SEP_TYPE_THERMAL) && (st_q != SEP_IDLE);

  // tenth-slot stop is the only programming trigger
  a_prog_start_slot: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(program_busy) |-> $past(stop_ev) && $past(wr_arm_q))
    else $error("program cycle began without a tenth-slot stop");
  a_page_query_ack: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && bit_q == 4'h8 && st_q == SEP_SEL && sh_q == {SEP_TYPE_PROTECT, SEP_CMD_PAGE0, 1'b1}
     && !program_busy) |=> ack_q == ~page_q)
    else $error("page query answer wrong");
  a_no_prot_novhv: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && bit_q == 4'h8 && st_q == SEP_SEL && sh_q[7:4] == SEP_TYPE_PROTECT && !sh_q[0]
     && sh_q[3:1] == SEP_CMD_CLEAR && !high_voltage_level) |=> !ack_q)
    else $error("clear accepted without high voltage");
  a_busy_no_array: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && bit_q == 4'h8 && st_q == SEP_SEL && program_busy
     && sh_q[7:4] == SEP_TYPE_ARRAY) |=> !ack_q)
    else $error("array answered while programming");
  a_addr_mismatch: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && bit_q == 4'h8 && st_q == SEP_SEL && sh_q[7:4] == SEP_TYPE_ARRAY
     && sh_q[3:1] != lba) |=> !ack_q)
    else $error("array acked foreign address");
  a_prot_data_nack: assert property (@(posedge ref_clk) disable iff (reset)
    (scl_fall && bit_q == 4'h8 && st_q == SEP_DATA && kind_q == SEP_TYPE_ARRAY
     && prot_q[blk_of(page_q, addr_q)]) |=> !ack_q)
    else $error("protected byte acknowledged");
  a_busy_length: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(program_busy) |-> program_busy [*8])
    else $error("program cycle ended early");
  a_page_stable: assert property (@(posedge ref_clk) disable iff (reset)
    !stop_ev |=> $stable(page_q))
    else $error("page changed without a stop");
endmodule // sep_eeprom_cmd

// ===== dv/sep_bus_master.sv
// two-wire bus master model: drives scl and pulls sda low open-drain style
`timescale 1ns/100ps
module sep_bus_master (
  // clock
  input  wire logic ref_clk,
  // two-wire bus
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_low
);
  // quarter of the link period in ref_clk cycles, 4 x 8 ns
  localparam int QTR = 4;

  // bus idles high and the clock stands still between frames
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_q();
    repeat (QTR) @(negedge ref_clk);
  endtask

  // sda falls while scl is high
  task automatic start_cond();
    sda_low = 1'b1;
    wait_q();
    scl_drv = 1'b0;
    wait_q();
  endtask

  // sda rises while scl is high; entered with scl low
  task automatic stop_cond();
    sda_low = 1'b1;
    wait_q();
    scl_drv = 1'b1;
    wait_q();
    sda_low = 1'b0;
    wait_q();
  endtask

  // one bit slot; data changes only while scl is low
  task automatic clock_bit(input logic v, output logic seen);
    sda_low = ~v;
    wait_q();
    scl_drv = 1'b1;
    wait_q();
    seen = sda_line;
    wait_q();
    scl_drv = 1'b0;
    wait_q();
  endtask

  // eight bits msb first, then a released ninth slot for the ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    ack = ~seen;
  endtask
endmodule // sep_bus_master

// ===== dv/sep_eeprom_cmd_tb.sv
// self-checking bench for the eeprom select, protection and page decoder
`timescale 1ns/100ps
module sep_eeprom_cmd_tb;
  import sep_pkg::*;
  // short program cycle, yet long enough for two select bytes inside it
  localparam int TW = 400;
  logic       ref_clk, reset, scl, sda_low, sda_line, sda_out, sda_oe;
  logic       busy, page, th_sel, th_valid, hv;
  logic [3:0] prot;
  logic [7:0] th_byte;
  logic [2:0] lba;
  logic [2:0] codes [4];
  int         mismatches, samples_checked;
  int         th_count = 0;

  // count thermal byte strobes, each one cycle wide
  always @(posedge ref_clk) if (th_valid === 1'b1) th_count <= th_count + 1;

  // pull-up on sda; either party may pull it low
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  sep_eeprom_cmd #(.TW_CYCLES(TW)) i_sep_eeprom_cmd (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_zero(lba[0]),
    .address_strap_one(lba[1]), .address_strap_two(lba[2]),
    .high_voltage_level(hv), .program_busy(busy), .array_page(page),
    .block_protected(prot), .thermal_select(th_sel), .thermal_byte(th_byte),
    .thermal_byte_valid(th_valid));

  sep_bus_master i_sep_bus_master (
    .ref_clk(ref_clk), .sda_line(sda_line), .scl_drv(scl), .sda_low(sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  // start, up to three bytes, stop; acks packed select-first
  task automatic xfer(input logic [7:0] s, a, d, input int n, output logic [2:0] acks);
    logic [7:0] b [3];
    b = '{s, a, d};
    acks = 3'b000;
    i_sep_bus_master.start_cond();
    for (int i = 0; i < n; i++) i_sep_bus_master.put_byte(b[i], acks[2-i]);
    i_sep_bus_master.stop_cond();
    repeat (4) @(negedge ref_clk);
  endtask

  // bounded wait for the program cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 1000) begin
      mismatches++;
      $display("MISMATCH %0t busy never fell", $time);
      summarize();
    end
  endtask

  task automatic clear_all();
    logic [2:0] k;
    hv = 1'b1; // master applies high voltage for protect commands
    xfer({SEP_TYPE_PROTECT, SEP_CMD_CLEAR, 1'b0}, 8'h00, 8'h00, 3, k);
    wait_idle();
    hv = 1'b0;
    check(prot, SEP_PROT_NONE, "clear all");
  endtask

  task automatic t_select_write();
    logic [2:0] k;
    xfer({SEP_TYPE_ARRAY, lba ^ 3'h1, 1'b0}, 8'h10, 8'h5a, 3, k);
    check(k, 3'b000, "foreign address answered");
    check(busy, 1'b0, "busy after nack");
    xfer({SEP_TYPE_ARRAY, lba, 1'b0}, 8'h10, 8'h5a, 3, k);
    check(k, 3'b111, "write acks");
    check(busy, 1'b1, "program cycle");
    xfer({SEP_TYPE_ARRAY, lba, 1'b0}, 8'h00, 8'h00, 1, k);
    check(k[2], 1'b0, "array answered while busy");
    xfer({SEP_TYPE_THERMAL, lba, 1'b0}, 8'h00, 8'h00, 1, k);
    check(k[2], 1'b1, "thermal while busy");
    wait_idle();
    xfer({SEP_TYPE_THERMAL, lba, 1'b0}, 8'h05, 8'ha5, 3, k);
    check(k, 3'b111, "thermal write acks");
    check(th_byte, 8'ha5, "thermal byte");
    check(8'(th_count), 8'h01, "thermal byte strobe");
    check(th_sel, 1'b0, "thermal selected after stop");
    check(busy, 1'b0, "thermal write programmed");
  endtask

  // stop inside the data byte must not program
  task automatic t_stray_stop();
    logic a;
    i_sep_bus_master.start_cond();
    i_sep_bus_master.put_byte({SEP_TYPE_ARRAY, lba, 1'b0}, a);
    i_sep_bus_master.put_byte(8'h20, a);
    for (int i = 0; i < 4; i++) i_sep_bus_master.clock_bit(1'b1, a);
    i_sep_bus_master.stop_cond();
    repeat (4) @(negedge ref_clk);
    check(busy, 1'b0, "stray stop programmed");
  endtask

  // every block code: refused without high voltage, then set, query, page, write
  task automatic t_protect();
    logic [2:0] k;
    for (int b = 0; b < 4; b++) begin
      xfer({SEP_TYPE_PROTECT, codes[b], 1'b0}, 8'h00, 8'h00, 3, k);
      wait_idle();
      check(prot, SEP_PROT_NONE, "set without high voltage");
      hv = 1'b1;
      xfer({SEP_TYPE_PROTECT, codes[b], 1'b0}, 8'h00, 8'h00, 3, k);
      wait_idle();
      hv = 1'b0;
      check(prot, 4'h1 << b, "one block set");
      xfer({SEP_TYPE_PROTECT, codes[b], 1'b1}, 8'h00, 8'h00, 1, k);
      check(k[2], 1'b0, "query protected");
      xfer({SEP_TYPE_PROTECT, codes[(b + 1) % 4], 1'b1}, 8'h00, 8'h00, 1, k);
      check(k[2], 1'b1, "query free");
      xfer({SEP_TYPE_PROTECT, b[1] ? SEP_CMD_PAGE1 : SEP_CMD_PAGE0, 1'b0}, 8'h00, 8'h00, 1, k);
      check(page, b[1], "page set");
      xfer({SEP_TYPE_PROTECT, SEP_CMD_PAGE0, 1'b1}, 8'h00, 8'h00, 1, k);
      check(k[2], b[1] ? 1'b0 : 1'b1, "page query");
      xfer({SEP_TYPE_ARRAY, lba, 1'b0}, {b[0], 7'h05}, 8'h33, 3, k);
      check(k, 3'b110, "protected data byte");
      check(busy, 1'b0, "protected write programmed");
      clear_all();
    end
  endtask

  initial begin
    codes = '{SEP_CMD_BLK0, SEP_CMD_BLK1, SEP_CMD_BLK2, SEP_CMD_BLK3};
    mismatches = 0;
    samples_checked = 0;
    reset = 1'b1;
    hv = 1'b0;
    lba = 3'h5;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    check({sda_oe, sda_out, busy, page}, 4'h0, "reset state");
    // startup quiet time before the first command
    repeat (20) @(negedge ref_clk);
    clear_all();
    t_select_write();
    t_stray_stop();
    t_protect();
    reset = 1'b1;
    @(negedge ref_clk);
    reset = 1'b0;
    check(page, 1'b0, "page after second reset");
    summarize();
  end
endmodule // sep_eeprom_cmd_tb
